// *** rtl/bss_pkg.sv ***
/*
 * Constants, selection decode and state type of the soft-start and
 * fault sequencer. Assumes a 100 MHz system clock.
 */
package bss_pkg;
	localparam int CLK_MHZ = 100;
	// oscillator settings, MHz
	localparam int OSC_MHZ_LO = 4;
	localparam int OSC_MHZ_MID = 7;
	localparam int OSC_MHZ_HI = 10;
	localparam logic [4:0] DIV_LO = 5'(CLK_MHZ / OSC_MHZ_LO);
	localparam logic [4:0] DIV_MID = 5'(CLK_MHZ / OSC_MHZ_MID);
	localparam logic [4:0] DIV_HI = 5'(CLK_MHZ / OSC_MHZ_HI);
	// soft start, in oscillator cycles (same count at every rate)
	localparam int SS_SHORT_US_LO = 64;
	localparam int SS_MID_US_LO = 512;
	localparam int SS_LONG_US_LO = 4096;
	localparam int SS_SHORT_LOG2 = $clog2(SS_SHORT_US_LO * OSC_MHZ_LO);
	localparam int SS_MID_LOG2 = $clog2(SS_MID_US_LO * OSC_MHZ_LO);
	localparam int SS_LONG_LOG2 = $clog2(SS_LONG_US_LO * OSC_MHZ_LO);
	// hiccup, in oscillator cycles
	localparam real HICCUP_MS_LO = 32.8;
	localparam int HICCUP_TICKS_DEF = int'(HICCUP_MS_LO * 1000.0) * OSC_MHZ_LO;
	// reference in mV and the window thresholds derived from it
	localparam int REF_NOM_MV = 500;
	localparam logic [9:0] REF_NOM = 10'(REF_NOM_MV);
	localparam logic [9:0] PG_LO = 10'(REF_NOM_MV * 95 / 100);
	localparam logic [9:0] PG_HI = 10'(REF_NOM_MV * 105 / 100);
	localparam logic [9:0] UV_TRIP = 10'(REF_NOM_MV * 90 / 100);
	localparam logic [9:0] OV_TRIP = 10'(REF_NOM_MV * 110 / 100);
	localparam logic [1:0] OC_TRIP_COUNT = 2'h3;
	// selection codes, one per programming resistor
	localparam logic [2:0] SEL_LAST_LO = 3'h2;
	localparam logic [2:0] SEL_LAST_MID = 3'h4;
	localparam logic [1:0] SS_CLS_SHORT = 2'h0;
	localparam logic [1:0] SS_CLS_MID = 2'h1;
	localparam logic [1:0] SS_CLS_LONG = 2'h2;
	// register map, byte addresses
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_SEL = 4'h8;
	localparam int CTRL_FORCE_OFF = 0;
	localparam int ST_OC = 0;
	localparam int ST_UV = 1;
	localparam int ST_OV = 2;
	localparam int ST_PG = 3;
	localparam int ST_STATE = 4;
	localparam int SEL_CURRENT_LIMIT_SELECT = 3;
	typedef enum logic [2:0] {
		ST_OFF, ST_PRECHG, ST_SOFT, ST_RUN, ST_HICCUP
	} bss_state_t;

	function automatic logic [4:0] sel_div(input logic [2:0] c);
		if (c <= SEL_LAST_LO)
			return DIV_LO;
		else if (c <= SEL_LAST_MID)
			return DIV_MID;
		return DIV_HI;
	endfunction : sel_div

	function automatic logic [1:0] sel_ss(input logic [2:0] c);
		case (c)
			3'h0, 3'h3, 3'h5: return SS_CLS_SHORT;
			3'h1, 3'h4, 3'h6: return SS_CLS_MID;
			default: return SS_CLS_LONG;
		endcase
	endfunction : sel_ss
endpackage : bss_pkg

// *** rtl/bss_sel_if.sv ***
/*
 * Carrier between the sequencer and its selection latch.
 * Assumes both ends share one clock.
 */
interface bss_sel_if;
	logic cap;
	logic [2:0] raw_code;
	logic raw_current_limit_select;
	logic [2:0] code;
	logic current_limit_select_high;
	logic [1:0] ss_class;
	logic osc_tick;
	logic sw_tick;
	modport ctl(output cap, raw_code, raw_current_limit_select,
		input code, current_limit_select_high, ss_class, osc_tick, sw_tick);
	modport lat(input cap, raw_code, raw_current_limit_select,
		output code, current_limit_select_high, ss_class, osc_tick, sw_tick);
endinterface : bss_sel_if

// *** rtl/bss_sel_latch.sv ***
/*
 * Selection latch and oscillator divider. Captures the frequency,
 * soft-start and current-limit straps on a capture strobe.
 * Assumes raw inputs are already synchronised.
 */
module bss_sel_latch
	import bss_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// sequencer side
	bss_sel_if.lat sel
);
	logic [4:0] div_cnt;
	logic half;

	// straps held between captures
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sel.code <= 3'h0;
			sel.current_limit_select_high <= 1'b1;
			sel.ss_class <= SS_CLS_SHORT;
		end else if (sel.cap) begin
			sel.code <= sel.raw_code;
			sel.ss_class <= sel_ss(sel.raw_code);
			sel.current_limit_select_high <= sel.raw_current_limit_select;
		end
	end

	// oscillator tick at the selected rate, switch tick at half of it
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_cnt <= 5'h0;
			half <= 1'b0;
			sel.osc_tick <= 1'b0;
			sel.sw_tick <= 1'b0;
		end else begin
			sel.osc_tick <= 1'b0;
			sel.sw_tick <= 1'b0;
			if (div_cnt >= sel_div(sel.code) - 5'h1) begin
				div_cnt <= 5'h0;
				sel.osc_tick <= 1'b1;
				half <= ~half;
				sel.sw_tick <= half;
			end else begin
				div_cnt <= div_cnt + 5'h1;
			end
		end
	end
endmodule : bss_sel_latch

// *** rtl/bss_sequencer.sv ***
/*
 * Soft-start, power-good and fault sequencer of a two-phase step-down
 * converter, with an Avalon-MM register slave. Assumes the feedback
 * code comes from a sampler on this clock; all other pins are async.
 */
// Overview of operation
// - soft start ramps the reference from zero to nominal half volt
// - during ramp: power good low, PLL off, under/over faults ignored
// - after ramp, run normally; power good follows the window
// - eight selector codes set oscillator rate and soft-start length
// - soft-start choice captured at power-up and each enable rise
// - low sides stay off until phase A high side switches
// - high side starts once reference exceeds feedback, or on entering run
// - power good released inside 95 to 105 percent, else pulled low
// - power good low on any fault or when enable is low
// - third consecutive overcurrent sets flag, stops switches
// - overcurrent restart only after hiccup counter expires
// - current limit selector: open is high limit, resistor lower
// - current limit captured at power-up, changes only on re-enable
// - run in forced continuous mode at light load
// - feedback beyond 90 or 110 percent stops switches, hiccups
// - oscillator rate captured at power-up, fixed while running
// - every start first completes capacitor precharge
module bss_sequencer
	import bss_pkg::*;
#(
	parameter int HICCUP_TICKS = HICCUP_TICKS_DEF,
	parameter int SS_LONG_TICKS_LOG2 = SS_LONG_LOG2
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// register bus
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// straps and analog status
	input wire logic enable_i,
	input wire logic [2:0] softstart_freq_select_i,
	input wire logic current_limit_select_i,
	input wire logic precharge_done_i,
	input wire logic hs_a_switching_i,
	input wire logic ocp_a_i,
	input wire logic ocp_b_i,
	input wire logic [9:0] feedback_sense_i,
	// power stage control
	output logic precharge_start_o,
	output logic [9:0] softstart_ref_o,
	output logic high_side_enable_o,
	output logic low_side_enable_o,
	output logic forced_continuous_mode_o,
	output logic pll_enable_o,
	output logic current_limit_high_o,
	output logic fault_o,
	// open-drain power good
	output logic power_good_out_o,
	output logic power_good_out_oe_o
);
	localparam int NPIN = 8;
	localparam logic [17:0] HICCUP_END = 18'(HICCUP_TICKS);
	localparam logic [2:0] BOOT_CAP = 3'h3;
	bss_sel_if sel();
	bss_sel_latch u_latch (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.sel(sel)
	);
	logic [NPIN-1:0] s1, s2, s3, pin;
	logic en_s, en_q, hsa_s, oca_s, ocb_s;
	bss_state_t state, next_state;
	logic [17:0] elapsed;
	logic [1:0] oc_cnt;
	logic hs_arm, ls_arm, force_off, uv, ov, in_win;
	logic [2:0] flags, boot_cnt;
	logic [31:0] rdata;
	logic oc_trip, ss_end, hic_end, req, take;
	logic [4:0] ss_sh;
	// three-stage synchronisers, a change counts when stages 2 and 3 agree
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			pin <= '0;
		end else begin
			s1 <= {enable_i, hs_a_switching_i, ocp_a_i, ocp_b_i,
				current_limit_select_i, softstart_freq_select_i};
			s2 <= s1;
			s3 <= s2;
			pin <= (s3 & ~(s2 ^ s3)) | (pin & (s2 ^ s3));
		end
	end
	assign {en_s, hsa_s, oca_s, ocb_s, sel.raw_current_limit_select, sel.raw_code} = pin;
	function automatic logic [9:0] ramp(input logic [17:0] el,
		input logic [4:0] sh);
		logic [27:0] p;
		p = 28'(el) * 28'(REF_NOM);
		return 10'(p >> sh);
	endfunction : ramp
	always_comb begin
		case (sel.ss_class)
			SS_CLS_SHORT: ss_sh = 5'(SS_SHORT_LOG2);
			SS_CLS_MID: ss_sh = 5'(SS_MID_LOG2);
			default: ss_sh = 5'(SS_LONG_TICKS_LOG2);
		endcase
	end
	assign uv = feedback_sense_i < UV_TRIP;
	assign ov = feedback_sense_i > OV_TRIP;
	assign in_win = feedback_sense_i >= PG_LO && feedback_sense_i <= PG_HI;
	assign ss_end = elapsed >= (18'h1 << ss_sh);
	assign hic_end = elapsed >= HICCUP_END;
	assign oc_trip = sel.sw_tick && (oca_s || ocb_s) &&
		oc_cnt == OC_TRIP_COUNT - 2'h1 &&
		(state == ST_SOFT || state == ST_RUN);
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF:
				if (en_s && !force_off)
					next_state = ST_PRECHG;
			ST_PRECHG:
				if (precharge_done_i)
					next_state = ST_SOFT;
			ST_SOFT:
				if (oc_trip)
					next_state = ST_HICCUP;
				else if (ss_end)
					next_state = ST_RUN;
			ST_RUN:
				if (oc_trip || uv || ov)
					next_state = ST_HICCUP;
			ST_HICCUP:
				if (hic_end)
					next_state = ST_PRECHG;
			default:
				next_state = ST_OFF;
		endcase
		if (!en_s || force_off)
			next_state = ST_OFF;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			state <= ST_OFF;
		else
			state <= next_state;
	end
	// straps taken once they settle after power-up and on every enable rise
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			boot_cnt <= 3'h0;
			en_q <= 1'b0;
			sel.cap <= 1'b0;
		end else begin
			if (boot_cnt <= BOOT_CAP)
				boot_cnt <= boot_cnt + 3'h1;
			en_q <= en_s;
			sel.cap <= boot_cnt == BOOT_CAP ||
				(en_s && !en_q);
		end
	end
	// oscillator-cycle counter shared by ramp and hiccup
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			elapsed <= 18'h0;
		else if (next_state != state)
			elapsed <= 18'h0;
		else if (sel.osc_tick && (state == ST_SOFT || state == ST_HICCUP))
			elapsed <= elapsed + 18'h1;
	end
	// consecutive overcurrent count, per switching cycle
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			oc_cnt <= 2'h0;
		else if (state != ST_SOFT && state != ST_RUN)
			oc_cnt <= 2'h0;
		else if (sel.sw_tick)
			oc_cnt <= (oca_s || ocb_s) ? oc_cnt + 2'h1 : 2'h0;
	end
	// start gating for a pre-biased output
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hs_arm <= 1'b0;
			ls_arm <= 1'b0;
		end else if (state != ST_SOFT && state != ST_RUN) begin
			hs_arm <= 1'b0;
			ls_arm <= 1'b0;
		end else begin
			if (softstart_ref_o > feedback_sense_i || state == ST_RUN)
				hs_arm <= 1'b1;
			if (hs_arm && hsa_s)
				ls_arm <= 1'b1;
		end
	end
	// power stage outputs
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			precharge_start_o <= 1'b0;
			softstart_ref_o <= 10'h0;
			high_side_enable_o <= 1'b0;
			low_side_enable_o <= 1'b0;
			forced_continuous_mode_o <= 1'b0;
			pll_enable_o <= 1'b0;
			current_limit_high_o <= 1'b1;
			fault_o <= 1'b0;
			power_good_out_o <= 1'b0;
			power_good_out_oe_o <= 1'b1;
		end else begin
			precharge_start_o <= state == ST_PRECHG;
			if (state == ST_RUN)
				softstart_ref_o <= REF_NOM;
			else if (state == ST_SOFT)
				softstart_ref_o <= ramp(elapsed, ss_sh);
			else
				softstart_ref_o <= 10'h0;
			high_side_enable_o <= hs_arm && next_state != ST_HICCUP;
			low_side_enable_o <= ls_arm && next_state != ST_HICCUP;
			forced_continuous_mode_o <= state == ST_RUN;
			pll_enable_o <= state == ST_RUN;
			current_limit_high_o <= sel.current_limit_select_high;
			fault_o <= state == ST_HICCUP;
			power_good_out_oe_o <= !(state == ST_RUN && in_win &&
				en_s && !force_off);
		end
	end
	// avalon slave: one wait cycle, then the answer
	assign req = avs_read_i || avs_write_i;
	assign take = req && !avs_waitrequest_o;

	always_comb begin
		rdata = 32'h0000_0000;
		case (avs_address_i)
			REG_CTRL: rdata[CTRL_FORCE_OFF] = force_off;
			REG_STATUS: begin
				rdata[ST_OV:ST_OC] = flags;
				rdata[ST_PG] = !power_good_out_oe_o;
				rdata[ST_STATE+:3] = state;
			end
			REG_SEL: begin
				rdata[2:0] = sel.code;
				rdata[SEL_CURRENT_LIMIT_SELECT] = sel.current_limit_select_high;
			end
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end else begin
			avs_waitrequest_o <= !(req && avs_waitrequest_o);
			if (avs_read_i && avs_waitrequest_o)
				avs_readdata_o <= rdata;
		end
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			force_off <= 1'b0;
		else if (take && avs_write_i && avs_address_i == REG_CTRL)
			force_off <= avs_writedata_i[CTRL_FORCE_OFF];
	end

	// sticky fault flags, write one to clear, a new event wins
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags <= 3'h0;
		end else begin
			if (take && avs_write_i && avs_address_i == REG_STATUS)
				flags <= flags & ~avs_writedata_i[ST_OV:ST_OC];
			if (oc_trip)
				flags[ST_OC] <= 1'b1;
			if (state == ST_RUN && uv)
				flags[ST_UV] <= 1'b1;
			if (state == ST_RUN && ov)
				flags[ST_OV] <= 1'b1;
		end
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	property p_soft_quiet;
		state == ST_SOFT |=> power_good_out_oe_o && !pll_enable_o;
	endproperty
	a_soft_quiet: assert property (p_soft_quiet)
		else $error("power good or pll active during ramp");
	property p_ramp_up;
		state == ST_SOFT && $past(state) == ST_SOFT
			|=> softstart_ref_o >= $past(softstart_ref_o);
	endproperty
	a_ramp_up: assert property (p_ramp_up)
		else $error("soft-start reference fell");
	property p_ss_end;
		state == ST_SOFT && ss_end && !oc_trip && en_s && !force_off
			|=> state == ST_RUN ##1 softstart_ref_o == REF_NOM;
	endproperty
	a_ss_end: assert property (p_ss_end)
		else $error("ramp end did not enter run at nominal");
	property p_hs_gate;
		state == ST_SOFT && !hs_arm &&
			softstart_ref_o <= feedback_sense_i |=> !hs_arm;
	endproperty
	a_hs_gate: assert property (p_hs_gate)
		else $error("high side armed below feedback");
	property p_ls_after_hs;
		low_side_enable_o |-> high_side_enable_o;
	endproperty
	a_ls_after_hs: assert property (p_ls_after_hs)
		else $error("low side on before high side");
	property p_pg_window;
		state == ST_RUN && !in_win |=> power_good_out_oe_o;
	endproperty
	a_pg_window: assert property (p_pg_window)
		else $error("power good released out of window");
	property p_pg_enable;
		!en_s |=> power_good_out_oe_o ##1 power_good_out_oe_o;
	endproperty
	a_pg_enable: assert property (p_pg_enable)
		else $error("power good released while disabled");
	property p_oc_trip;
		oc_trip && en_s && !force_off |=> state == ST_HICCUP
			##1 !high_side_enable_o && fault_o;
	endproperty
	a_oc_trip: assert property (p_oc_trip)
		else $error("third overcurrent did not shut down");
	property p_hiccup_hold;
		state == ST_HICCUP |=> !low_side_enable_o && oc_cnt == 2'h0 &&
			power_good_out_oe_o;
	endproperty
	a_hiccup_hold: assert property (p_hiccup_hold)
		else $error("switching or count during hiccup");
	property p_hiccup_wait;
		state == ST_HICCUP && !hic_end |=> state != ST_PRECHG;
	endproperty
	a_hiccup_wait: assert property (p_hiccup_wait)
		else $error("restart before hiccup expiry");
	property p_uvov;
		state == ST_RUN && (uv || ov) && en_s && !force_off
			|=> state == ST_HICCUP;
	endproperty
	a_uvov: assert property (p_uvov)
		else $error("output fault did not stop converter");
	property p_forced_continuous_mode;
		state == ST_RUN |=> forced_continuous_mode_o;
	endproperty
	a_forced_continuous_mode: assert property (p_forced_continuous_mode)
		else $error("not in forced continuous mode");
	property p_sel_hold;
		!sel.cap |=> $stable(sel.code) && $stable(sel.current_limit_select_high);
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("selection changed without capture");
	property p_prechg;
		$rose(state == ST_SOFT) |-> $past(state) == ST_PRECHG;
	endproperty
	a_prechg: assert property (p_prechg)
		else $error("soft start without precharge");

	c_run: cover property (state == ST_SOFT ##1 state == ST_RUN);
	c_oc: cover property (oc_trip ##1 state == ST_HICCUP);
	c_restart: cover property (state == ST_HICCUP ##1 state == ST_PRECHG);
	c_pg: cover property (!power_good_out_oe_o);
endmodule : bss_sequencer

// *** test/bss_sequencer_tb.sv ***
/*
 * Self-checking bench of the sequencer: startup, window, straps,
 * overcurrent and output faults. Assumes the stage model beside it.
 */
module bss_sequencer_tb;
	import bss_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [9:0] fb; logic oe;} bss_row_t;
	bss_row_t rows [8] = '{'{10'h1f4, 0}, '{10'h1db, 0}, '{10'h1da, 1},
		'{10'h20d, 0}, '{10'h20e, 1}, '{10'h1c3, 1}, '{10'h225, 1},
		'{10'h1f4, 0}};
	logic sys_clk_i, nrst_i, avs_read_i, avs_write_i, enable_i;
	logic [3:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [2:0] sel_code;
	logic current_limit_select_sel, pc_done, hs_sw, ocp_a, ocp_b;
	logic [9:0] fb_cmd, fb, softstart_ref_o;
	logic [1:0] oc_cmd;
	logic avs_waitrequest_o, precharge_start_o, high_side_enable_o;
	logic low_side_enable_o, forced_continuous_mode, pll_enable_o, current_limit_high_o;
	logic fault_o, pg_o, power_good_out_oe_o;
	int errors, checked, viol, n;

	bss_sequencer #(.HICCUP_TICKS(50), .SS_LONG_TICKS_LOG2(6))
	bss_sequencer_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .enable_i(enable_i),
		.softstart_freq_select_i(sel_code),
		.current_limit_select_i(current_limit_select_sel), .precharge_done_i(pc_done),
		.hs_a_switching_i(hs_sw), .ocp_a_i(ocp_a), .ocp_b_i(ocp_b),
		.feedback_sense_i(fb), .precharge_start_o(precharge_start_o),
		.softstart_ref_o(softstart_ref_o),
		.high_side_enable_o(high_side_enable_o),
		.low_side_enable_o(low_side_enable_o),
		.forced_continuous_mode_o(forced_continuous_mode), .pll_enable_o(pll_enable_o),
		.current_limit_high_o(current_limit_high_o), .fault_o(fault_o),
		.power_good_out_o(pg_o),
		.power_good_out_oe_o(power_good_out_oe_o));

	bss_stage_model bss_stage_model_i (.sys_clk_i(sys_clk_i),
		.precharge_start_i(precharge_start_o),
		.high_side_enable_i(high_side_enable_o), .fb_cmd_i(fb_cmd),
		.oc_cmd_i(oc_cmd), .precharge_done_o(pc_done),
		.hs_a_switching_o(hs_sw), .feedback_sense_o(fb),
		.ocp_a_o(ocp_a), .ocp_b_o(ocp_b));

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cyc(input int c);
		repeat (c) @(posedge sys_clk_i);
	endtask : cyc

	// one Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		avs_writedata_i <= d;
		@(posedge sys_clk_i);
		while (avs_waitrequest_o !== 1'b0)
			@(posedge sys_clk_i);
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : bus

	task automatic wait_hi(ref logic s, input int lim);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk("wait", 0, n >= lim);
	endtask : wait_hi

	// start into a pre-biased output, feedback moves once switching
	task automatic power_up(input int lim);
		logic pre, pc;
		pre = 1'b1;
		pc = 1'b0;
		viol = 0;
		n = 0;
		fb_cmd <= 10'h0c8;
		enable_i <= 1'b1;
		while (pll_enable_o !== 1'b1 && n < lim) begin
			@(posedge sys_clk_i);
			n++;
			if (precharge_start_o)
				pc = 1'b1;
			if (pre && high_side_enable_o && softstart_ref_o <= fb)
				viol++;
			if (low_side_enable_o && !hs_sw)
				viol++;
			if (softstart_ref_o != 0 && pll_enable_o !== 1'b1 &&
				(power_good_out_oe_o !== 1'b1 || fault_o !== 1'b0))
				viol++;
			if (pre && high_side_enable_o) begin
				pre = 1'b0;
				fb_cmd <= 10'h1f4;
			end
		end
		chk("precharge", 1, pc);
		chk("startup", 0, viol);
		chk("run", 1, n < lim);
		chk("ref", {22'h0, REF_NOM}, {22'h0, softstart_ref_o});
		chk("forced_continuous_mode", 1, forced_continuous_mode);
		cyc(4);
		chk("pg released", 0, power_good_out_oe_o);
		$display("test startup done");
	endtask : power_up

	initial begin
		repeat (40000) @(posedge sys_clk_i);
		errors++;
		end_of_test();
	end

	initial begin
		nrst_i = 1'b0;
		avs_address_i = 4'h0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0;
		enable_i = 1'b0;
		sel_code = 3'h2;
		current_limit_select_sel = 1'b0;
		fb_cmd = 10'h0;
		oc_cmd = 2'h0;
		errors = 0;
		checked = 0;
		cyc(20);
		chk("rst wait", 1, avs_waitrequest_o);
		chk("rst pg oe", 1, power_good_out_oe_o);
		chk("rst current_limit_select", 1, current_limit_high_o);
		chk("rst fault", 0, fault_o);
		nrst_i <= 1'b1;
		cyc(10);
		chk("disabled pg oe", 1, power_good_out_oe_o);
		bus(0, REG_STATUS, 0);
		chk("state off", 0, rd[6:4]);
		bus(0, REG_SEL, 0);
		chk("boot sel", 32'h0000_0002, rd);
		chk("boot current_limit_select", 0, current_limit_high_o);
		current_limit_select_sel <= 1'b1;
		$display("test reset done");
		power_up(20000);
		foreach (rows[i]) begin
			fb_cmd <= rows[i].fb;
			cyc(5);
			chk("pg window", rows[i].oe, power_good_out_oe_o);
			chk("no fault", 0, fault_o);
		end
		chk("pg level", 0, pg_o);
		$display("test window done");
		bus(0, REG_SEL, 0);
		chk("sel", 32'h0000_000a, rd);
		bus(0, 4'hc, 0);
		chk("unmapped", 0, rd);
		sel_code <= 3'h7;
		current_limit_select_sel <= 1'b0;
		cyc(10);
		bus(0, REG_SEL, 0);
		chk("sel hold", 32'h0000_000a, rd);
		chk("current_limit_select hold", 1, current_limit_high_o);
		enable_i <= 1'b0;
		cyc(10);
		chk("enable low pg", 1, power_good_out_oe_o);
		chk("enable low hs", 0, high_side_enable_o);
		power_up(5000);
		bus(0, REG_SEL, 0);
		chk("sel new", 32'h0000_0007, rd);
		chk("current_limit_select new", 0, current_limit_high_o);
		$display("test straps done");
		oc_cmd <= 2'h1;
		cyc(35);
		oc_cmd <= 2'h0;
		cyc(60);
		chk("two oc no trip", 0, fault_o);
		oc_cmd <= 2'h2;
		wait_hi(fault_o, 200);
		oc_cmd <= 2'h0;
		chk("oc hs", 0, high_side_enable_o);
		chk("oc ls", 0, low_side_enable_o);
		chk("oc pg", 1, power_good_out_oe_o);
		bus(0, REG_STATUS, 0);
		chk("oc flag", 1, rd[0]);
		chk("hiccup state", 4, rd[6:4]);
		bus(1, REG_STATUS, 32'h0000_0007);
		bus(0, REG_STATUS, 0);
		chk("flag cleared", 0, rd[2:0]);
		cyc(300);
		chk("hiccup wait", 1, fault_o);
		chk("hiccup pg", 1, power_good_out_oe_o);
		power_up(3000);
		$display("test overcurrent done");
		for (int i = 0; i < 2; i++) begin
			fb_cmd <= i ? 10'h227 : 10'h1c1;
			wait_hi(fault_o, 20);
			chk("uvov hs", 0, high_side_enable_o);
			chk("uvov pg", 1, power_good_out_oe_o);
			bus(0, REG_STATUS, 0);
			chk("uvov flag", 1, rd[1 + i]);
			power_up(3000);
			bus(1, REG_STATUS, 32'h0000_0007);
		end
		$display("test uvov done");
		bus(1, REG_CTRL, 32'h0000_0001);
		cyc(3);
		chk("forced off pll", 0, pll_enable_o);
		chk("forced off pg", 1, power_good_out_oe_o);
		bus(0, REG_STATUS, 0);
		chk("forced off state", 0, rd[6:4]);
		$display("test force off done");
		end_of_test();
	end
endmodule : bss_sequencer_tb

// *** test/bss_stage_model.sv ***
/*
 * Power stage model: precharge completion, phase A switching echo,
 * feedback and overcurrent levels as the bench commands them.
 * Assumes the sequencer's clock.
 */
module bss_stage_model (
	// clock
	input wire logic sys_clk_i,
	// from the sequencer
	input wire logic precharge_start_i,
	input wire logic high_side_enable_i,
	// bench commands
	input wire logic [9:0] fb_cmd_i,
	input wire logic [1:0] oc_cmd_i,
	// to the sequencer
	output logic precharge_done_o,
	output logic hs_a_switching_o,
	output logic [9:0] feedback_sense_o,
	output logic ocp_a_o,
	output logic ocp_b_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pc_cnt = 4'h0;
	// precharge takes sixteen cycles, done holds until start drops
	always_ff @(posedge sys_clk_i) begin
		if (!precharge_start_i)
			pc_cnt <= 4'h0;
		else if (pc_cnt != 4'hf)
			pc_cnt <= pc_cnt + 4'h1;
		precharge_done_o <= precharge_start_i && pc_cnt == 4'hf;
		hs_a_switching_o <= high_side_enable_i;
	end
	assign feedback_sense_o = fb_cmd_i;
	assign ocp_a_o = oc_cmd_i[0];
	assign ocp_b_o = oc_cmd_i[1];
endmodule : bss_stage_model
